// ### hw/bcgu_core.v
// Base clock generation unit: source detectors, PLL divider logic, fractional dividers,
// glitch-free output generators and an APB register slave, all on the control clock mclk.
// Assumes source clocks arrive slower than mclk/2 as pins; the analog PLL core and lock
// detector sit outside and deliver pll_core_in and pll_lock_in.
//
// Operation
// - Twelve base clocks, index ten reserved
// - Safe and control clocks use ring only
// - Ring oscillator has no power-down
// - Seven dividers scale chosen source by L/D
// - PLL reference is crystal; sources shareable
// - Invalid select kept, other fields written
// - Reset selects ring oscillator everywhere
// - Inactive sources masked from general base and divider select writes
// - Detector: absent after 32 edgeless cycles
// - All absent after reset until detected
// - Events on activation and deactivation
// - Failed selected source is not replaced
// - Glitch-free switch with low hold
// - PLL switches wait for lock
// - Stuck-high clock forced low after 32
// - Post divider 2/4/8/16 or direct
// - Feedback divider by M, lock flag
// - Extra phases aligned when lock rises on a core edge
// - Power-down resets dividers, clears lock
// - Control logic on always-on clock
// - Second instance: USB input choice, pin
`timescale 1ns/10ps
`include "bcgu_defines.vh"

module bcgu_core #(
	parameter IS_SECOND = 0,
	parameter FD_W      = 8,
	parameter M_W       = 8
) (
	input  wire        mclk,
	input  wire        rst_n,
	input  wire        ce,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        ring_oscillator,
	input  wire        xtal_in,
	input  wire        pll_core_in,
	input  wire        pll_lock_in,
	input  wire        usb_gen_input_a,
	input  wire        usb_gen_input_b,
	output reg  [11:0] base_clk,
	output reg         pll_ref_clk,
	output reg         pll_fb_clk,
	output reg         pll_powerdown,
	output reg         clk_out_pin,
	output reg  [11:0] clk_on_evt,
	output reg  [11:0] clk_off_evt
);

	localparam ST_RUN  = 2'b00;
	localparam ST_WLOW = 2'b01;
	localparam ST_HOLD = 2'b10;
	localparam [31:0] PLL_RST = `BCGU_PLL_RESET;

	// Synchronisers for pins: stage one feeds stage two only
	reg  [4:0]  sync1;
	reg  [4:0]  sync2;
	reg  [4:0]  sync3;
	wire [4:0]  pin_now = {usb_gen_input_b, usb_gen_input_a, pll_core_in, xtal_in, ring_oscillator};

	reg  [11:0] src_lvl;
	reg  [11:0] src_prev;
	wire [11:0] src_edge = src_lvl & ~src_prev;
	wire [11:0] src_fall = src_prev & ~src_lvl;
	reg  [11:0] present;
	reg  [5:0]  det_cnt [0:11];
	reg  [11:0] evt_on_en;
	reg  [11:0] evt_off_en;

	reg  [3:0]  sel_cfg [0:11];
	reg  [3:0]  cur_sel [0:11];
	reg  [1:0]  gst     [0:11];
	reg  [5:0]  gcnt    [0:11];

	reg         pll_pd;
	reg         pll_direct;
	reg  [1:0]  pll_psel;
	reg         pll_extra_phase_enable;
	reg         pll_refb;
	reg  [M_W-1:0] pll_m;
	reg  [3:0]  pll_sel;
	reg  [3:0]  pc0;
	reg  [3:0]  pc1;
	reg  [3:0]  pc2;
	reg  [M_W-1:0] fb_cnt;
	reg         lock;
	reg         lock_d;
	reg         main_prev;
	reg         lock_s1;
	reg         pll_lock_in_s;

	reg  [3:0]  fd_sel  [0:6];
	reg  [FD_W-1:0] fd_l [0:6];
	reg  [FD_W-1:0] fd_d [0:6];
	reg  [FD_W:0]   fd_acc [0:6];
	reg  [5:0]  fd_hold [0:6];
	reg  [6:0]  fd_out;

	wire        core_edge = sync2[2] & ~sync3[2];
	wire [4:0]  pll_per   = 5'h02 << pll_psel;
	wire        ref_ok    = (IS_SECOND != 0) ? present[`BCGU_SRC_XTAL] | 1'b1 :
	                        (pll_sel == `BCGU_SRC_XTAL) & present[`BCGU_SRC_XTAL];
	wire        acc_wr    = psel & penable & pready & pwrite;
	wire [3:0]  wsel      = pwdata[`BCGU_SEL_LSB+3:`BCGU_SEL_LSB];
	wire        wr_pll    = acc_wr & (paddr == `BCGU_OFS_PLL);
	reg  [31:0] rd_val;
	reg         rd_hit;

	function src_is_pll;
		input [3:0] s;
		begin
			src_is_pll = (s >= `BCGU_SRC_PLL0) && (s <= `BCGU_SRC_PLL240);
		end
	endfunction

	// kind: 0 output generator, 1 ring-only generator, 2 divider, 3 PLL
	function sel_ok;
		input [1:0]  kind;
		input [3:0]  s;
		input [11:0] pres;
		begin
			case (kind)
				2'd1: sel_ok = (s == `BCGU_SRC_RING);
				2'd2: sel_ok = (s < `BCGU_SRC_FDIV0) && pres[s];
				2'd3: sel_ok = (s == `BCGU_SRC_XTAL);
				default: sel_ok = (s <= `BCGU_SRC_LAST) && pres[s];
			endcase
		end
	endfunction

	// Phase counter start for the 120/240 degree outputs, power-of-two period
	function [3:0] ph_start;
		input [3:0] c;
		input [4:0] per;
		input [1:0] k;
		reg   [6:0] sub;
		reg   [6:0] sum;
		begin
			sub = ({2'b00, per} * {5'b0, k}) / 7'd3;
			sum = {3'b000, c} + {2'b00, per} - sub;
			ph_start = sum[3:0] & (per[3:0] - 4'h1);
		end
	endfunction

	// Pin capture, source levels and activity detectors
	always @(posedge mclk or negedge rst_n) begin : det_seq
		integer i;
		if (!rst_n) begin
			sync1       <= 5'h00;
			sync2       <= 5'h00;
			sync3       <= 5'h00;
			src_lvl     <= 12'h000;
			src_prev    <= 12'h000;
			present     <= 12'h000;
			clk_on_evt  <= 12'h000;
			clk_off_evt <= 12'h000;
			for (i = 0; i < 12; i = i + 1) begin
				det_cnt[i] <= 6'h00;
			end
		end else if (ce) begin
			sync1    <= pin_now;
			sync2    <= sync1;
			sync3    <= sync2;
			src_prev <= src_lvl;
			// Ring level is used straight; nothing can power it down
			src_lvl[0] <= sync2[0];
			src_lvl[1] <= sync2[1];
			if (pll_pd) begin
				src_lvl[4:2] <= 3'b000;
			end else if (pll_direct) begin
				src_lvl[4:2] <= {3{sync2[2]}} & {pll_extra_phase_enable, pll_extra_phase_enable, 1'b1};
			end else begin
				src_lvl[2] <= ~pc0[pll_psel];
				src_lvl[3] <= pll_extra_phase_enable & ~pc1[pll_psel];
				src_lvl[4] <= pll_extra_phase_enable & ~pc2[pll_psel];
			end
			src_lvl[11:5] <= fd_out;
			for (i = 0; i < 12; i = i + 1) begin
				clk_on_evt[i]  <= 1'b0;
				clk_off_evt[i] <= 1'b0;
				if (src_edge[i]) begin
					det_cnt[i] <= 6'h00;
					present[i] <= 1'b1;
					clk_on_evt[i] <= ~present[i] & evt_on_en[i];
				end else if (det_cnt[i] == `BCGU_DET_LIMIT - 6'h01) begin
					det_cnt[i] <= `BCGU_DET_LIMIT;
					present[i] <= 1'b0;
					clk_off_evt[i] <= present[i] & evt_off_en[i];
				end else if (det_cnt[i] != `BCGU_DET_LIMIT) begin
					det_cnt[i] <= det_cnt[i] + 6'h01;
				end
			end
		end
	end

	// PLL divider chain: post divider, extra phases, feedback divider, lock
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pc0         <= 4'h0;
			pc1         <= 4'h0;
			pc2         <= 4'h0;
			fb_cnt      <= {M_W{1'b0}};
			pll_fb_clk  <= 1'b0;
			lock        <= 1'b0;
			lock_d      <= 1'b0;
			main_prev   <= 1'b0;
			pll_ref_clk <= 1'b0;
			clk_out_pin <= 1'b0;
		end else if (ce) begin
			lock_d    <= lock;
			main_prev <= src_lvl[2];
			if (IS_SECOND != 0) begin
				pll_ref_clk <= pll_refb ? sync2[4] : sync2[3];
				clk_out_pin <= pll_refb ? sync2[3] : sync2[4];
			end else begin
				pll_ref_clk <= sync2[1];
				clk_out_pin <= 1'b0;
			end
			if (pll_pd) begin
				pc0        <= 4'h0;
				pc1        <= 4'h0;
				pc2        <= 4'h0;
				fb_cnt     <= {M_W{1'b0}};
				pll_fb_clk <= 1'b0;
				lock       <= 1'b0;
			end else begin
				lock <= pll_lock_in_s & ref_ok;
				if (core_edge) begin
					pc0 <= (pc0 == pll_per[3:0] - 4'h1) ? 4'h0 : pc0 + 4'h1;
					if (lock & ~lock_d) begin
						// Phase dividers ran free before lock; realign now
						pc1 <= ph_start(pc0 + 4'h1, pll_per, 2'd1);
						pc2 <= ph_start(pc0 + 4'h1, pll_per, 2'd2);
					end else begin
						pc1 <= (pc1 >= pll_per[3:0] - 4'h1) ? 4'h0 : pc1 + 4'h1;
						pc2 <= (pc2 >= pll_per[3:0] - 4'h1) ? 4'h0 : pc2 + 4'h1;
					end
				end
				if (src_lvl[2] & ~main_prev) begin
					if (fb_cnt >= pll_m - 1'b1) begin
						fb_cnt     <= {M_W{1'b0}};
						pll_fb_clk <= ~pll_fb_clk;
					end else begin
						fb_cnt <= fb_cnt + 1'b1;
					end
				end
			end
		end
	end

	// Lock pin is analog; it gets its own two-stage capture
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			lock_s1       <= 1'b0;
			pll_lock_in_s <= 1'b0;
		end else if (ce) begin
			lock_s1       <= pll_lock_in;
			pll_lock_in_s <= lock_s1;
		end
	end

	// Fractional dividers: one input high phase per L/D overflow
	always @(posedge mclk or negedge rst_n) begin : fd_seq
		integer i;
		if (!rst_n) begin
			fd_out <= 7'h00;
			for (i = 0; i < 7; i = i + 1) begin
				fd_acc[i]  <= {(FD_W+1){1'b0}};
				fd_hold[i] <= 6'h00;
			end
		end else if (ce) begin
			for (i = 0; i < 7; i = i + 1) begin
				if (acc_wr && (paddr == `BCGU_OFS_FDIV0 + i * 4) && sel_ok(2'd2, wsel, present)
				    && (wsel != fd_sel[i])) begin
					// Source change: drop output and restart from a clean phase
					fd_hold[i] <= `BCGU_HOLD_CYC;
					fd_out[i]  <= 1'b0;
					fd_acc[i]  <= {(FD_W+1){1'b0}};
				end else if (fd_hold[i] != 6'h00) begin
					fd_hold[i] <= fd_hold[i] - 6'h01;
				end else if (src_edge[fd_sel[i]]) begin
					if (fd_acc[i] + {1'b0, fd_l[i]} >= {1'b0, fd_d[i]}) begin
						fd_acc[i] <= fd_acc[i] + {1'b0, fd_l[i]} - {1'b0, fd_d[i]};
						fd_out[i] <= 1'b1;
					end else begin
						fd_acc[i] <= fd_acc[i] + {1'b0, fd_l[i]};
						fd_out[i] <= 1'b0;
					end
				end else if (src_fall[fd_sel[i]]) begin
					// Drop with the source so equal L and D pass the clock through
					fd_out[i] <= 1'b0;
				end
			end
		end
	end

	// Output generators, one per base clock except the reserved index
	always @(posedge mclk or negedge rst_n) begin : gen_seq
		integer i;
		if (!rst_n) begin
			base_clk <= 12'h000;
			for (i = 0; i < 12; i = i + 1) begin
				cur_sel[i] <= `BCGU_SRC_RING;
				gst[i]     <= ST_RUN;
				gcnt[i]    <= 6'h00;
			end
		end else if (ce) begin
			for (i = 0; i < 12; i = i + 1) begin
				if (i == `BCGU_RSVD_BASE) begin
					base_clk[i] <= 1'b0;
				end else begin
					case (gst[i])
						ST_RUN: begin
							base_clk[i] <= src_lvl[cur_sel[i]];
							gcnt[i]     <= 6'h00;
							if (sel_cfg[i] != cur_sel[i]) begin
								gst[i] <= ST_WLOW;
							end
						end
						ST_WLOW: begin
							if (!src_lvl[cur_sel[i]] || gcnt[i] == `BCGU_DET_LIMIT) begin
								base_clk[i] <= 1'b0;
								gst[i]      <= ST_HOLD;
								gcnt[i]     <= 6'h00;
							end else begin
								base_clk[i] <= 1'b1;
								gcnt[i]     <= gcnt[i] + 6'h01;
							end
						end
						ST_HOLD: begin
							base_clk[i] <= 1'b0;
							if (gcnt[i] < `BCGU_HOLD_CYC) begin
								gcnt[i] <= gcnt[i] + 6'h01;
							end else if (!(src_is_pll(sel_cfg[i]) || src_is_pll(cur_sel[i]))
							             || lock) begin
								cur_sel[i] <= sel_cfg[i];
								gst[i]     <= ST_RUN;
							end
						end
						default: begin
							base_clk[i] <= 1'b0;
							gst[i]      <= ST_RUN;
						end
					endcase
				end
			end
		end
	end

	// Register writes; select fields refuse invalid sources, general base and divider selects also inactive ones
	always @(posedge mclk or negedge rst_n) begin : reg_seq
		integer i;
		if (!rst_n) begin
			pll_pd        <= PLL_RST[`BCGU_PLL_PD];
			pll_powerdown <= 1'b1;
			pll_direct    <= 1'b0;
			pll_psel      <= 2'b00;
			pll_extra_phase_enable     <= 1'b0;
			pll_refb      <= 1'b0;
			pll_m         <= `BCGU_M_RESET;
			pll_sel       <= `BCGU_SRC_RING;
			evt_on_en     <= 12'h000;
			evt_off_en    <= 12'h000;
			for (i = 0; i < 12; i = i + 1) begin
				sel_cfg[i] <= `BCGU_SRC_RING;
			end
			for (i = 0; i < 7; i = i + 1) begin
				fd_sel[i] <= `BCGU_SRC_RING;
				fd_l[i]   <= `BCGU_FD_L_RESET;
				fd_d[i]   <= `BCGU_FD_D_RESET;
			end
		end else if (ce) begin
			pll_powerdown <= pll_pd;
			if (acc_wr) begin
				for (i = 0; i < 12; i = i + 1) begin
					if (paddr == `BCGU_OFS_BASE0 + i * 4 && i != `BCGU_RSVD_BASE &&
					    sel_ok((i == 0 || i == 2) ? 2'd1 : 2'd0, wsel, present)) begin
						sel_cfg[i] <= wsel;
					end
				end
				for (i = 0; i < 7; i = i + 1) begin
					if (paddr == `BCGU_OFS_FDIV0 + i * 4) begin
						fd_l[i] <= pwdata[`BCGU_FD_L_LSB+FD_W-1:`BCGU_FD_L_LSB];
						fd_d[i] <= pwdata[`BCGU_FD_D_LSB+FD_W-1:`BCGU_FD_D_LSB];
						if (sel_ok(2'd2, wsel, present)) begin
							fd_sel[i] <= wsel;
						end
					end
				end
				if (wr_pll) begin
					pll_pd     <= pwdata[`BCGU_PLL_PD];
					pll_direct <= pwdata[`BCGU_PLL_DIRECT];
					pll_psel   <= pwdata[`BCGU_PLL_PSEL_LSB+1:`BCGU_PLL_PSEL_LSB];
					pll_extra_phase_enable  <= pwdata[`BCGU_PLL_EXTRA_PHASE_ENABLE];
					pll_refb   <= pwdata[`BCGU_PLL_REFB];
					pll_m      <= pwdata[`BCGU_PLL_M_LSB+M_W-1:`BCGU_PLL_M_LSB];
					if (sel_ok(2'd3, wsel, present)) begin
						pll_sel <= wsel;
					end
				end
				if (paddr == `BCGU_OFS_EVTEN) begin
					evt_on_en  <= pwdata[11:0];
					evt_off_en <= pwdata[`BCGU_EN_OFF_LSB+11:`BCGU_EN_OFF_LSB];
				end
			end
		end
	end

	// Read decode
	always @* begin : rd_comb
		integer i;
		i      = 0;
		rd_val = 32'h0000_0000;
		rd_hit = 1'b0;
		for (i = 0; i < 12; i = i + 1) begin
			if (paddr == `BCGU_OFS_BASE0 + i * 4) begin
				rd_hit = 1'b1;
				if (i != `BCGU_RSVD_BASE) begin
					rd_val[`BCGU_SEL_LSB+3:`BCGU_SEL_LSB] = sel_cfg[i];
				end
			end
		end
		for (i = 0; i < 7; i = i + 1) begin
			if (paddr == `BCGU_OFS_FDIV0 + i * 4) begin
				rd_hit = 1'b1;
				rd_val[`BCGU_FD_L_LSB+FD_W-1:`BCGU_FD_L_LSB] = fd_l[i];
				rd_val[`BCGU_FD_D_LSB+FD_W-1:`BCGU_FD_D_LSB] = fd_d[i];
				rd_val[`BCGU_SEL_LSB+3:`BCGU_SEL_LSB]        = fd_sel[i];
			end
		end
		if (paddr == `BCGU_OFS_PLL) begin
			rd_hit = 1'b1;
			rd_val[`BCGU_PLL_PD]     = pll_pd;
			rd_val[`BCGU_PLL_DIRECT] = pll_direct;
			rd_val[`BCGU_PLL_PSEL_LSB+1:`BCGU_PLL_PSEL_LSB] = pll_psel;
			rd_val[`BCGU_PLL_EXTRA_PHASE_ENABLE]  = pll_extra_phase_enable;
			rd_val[`BCGU_PLL_REFB]   = pll_refb;
			rd_val[`BCGU_PLL_M_LSB+M_W-1:`BCGU_PLL_M_LSB] = pll_m;
			rd_val[`BCGU_SEL_LSB+3:`BCGU_SEL_LSB] = pll_sel;
		end
		if (paddr == `BCGU_OFS_STATUS) begin
			rd_hit = 1'b1;
			rd_val[11:0]           = present;
			rd_val[`BCGU_ST_LOCK]  = lock;
			rd_val[`BCGU_ST_BUSY]  = (gst[1] != ST_RUN);
		end
		if (paddr == `BCGU_OFS_EVTEN) begin
			rd_hit = 1'b1;
			rd_val[11:0] = evt_on_en;
			rd_val[`BCGU_EN_OFF_LSB+11:`BCGU_EN_OFF_LSB] = evt_off_en;
		end
	end

	// APB answer: pready rises one cycle into the access phase
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (ce) begin
			if (psel && penable && !pready) begin
				pready  <= 1'b1;
				prdata  <= pwrite ? 32'h0000_0000 : rd_val;
				pslverr <= ~rd_hit;
			end else begin
				pready  <= 1'b0;
				prdata  <= 32'h0000_0000;
				pslverr <= 1'b0;
			end
		end
	end

endmodule

// ### hw/bcgu_defines.vh
// Constants of the base clock generation unit: register map, fields, reset values, counts.
// Included by the core; definitions only.
`ifndef BCGU_DEFINES_VH
`define BCGU_DEFINES_VH

// Register byte offsets
`define BCGU_OFS_BASE0     8'h00
`define BCGU_OFS_PLL       8'h30
`define BCGU_OFS_STATUS    8'h34
`define BCGU_OFS_EVTEN     8'h38
`define BCGU_OFS_FDIV0     8'h40

// Counts
`define BCGU_NUM_BASE      12
`define BCGU_RSVD_BASE     10
`define BCGU_NUM_FRACTIONAL_DIVIDER      7
`define BCGU_NUM_SRC       12
`define BCGU_DET_LIMIT     6'h20
`define BCGU_HOLD_CYC      6'h02

// Source select encodings
`define BCGU_SRC_RING      4'h0
`define BCGU_SRC_XTAL      4'h1
`define BCGU_SRC_PLL0      4'h2
`define BCGU_SRC_PLL240    4'h4
`define BCGU_SRC_FDIV0     4'h5
`define BCGU_SRC_LAST      4'hB

// Field positions
`define BCGU_SEL_LSB       24
`define BCGU_PLL_PD        0
`define BCGU_PLL_DIRECT    1
`define BCGU_PLL_PSEL_LSB  2
`define BCGU_PLL_EXTRA_PHASE_ENABLE     4
`define BCGU_PLL_REFB      5
`define BCGU_PLL_M_LSB     8
`define BCGU_FD_L_LSB      0
`define BCGU_FD_D_LSB      8
`define BCGU_ST_LOCK       16
`define BCGU_ST_BUSY       17
`define BCGU_EN_OFF_LSB    16

// Reset values
`define BCGU_PLL_RESET     32'h0000_0101
`define BCGU_M_RESET       8'h01
`define BCGU_FD_L_RESET    8'h01
`define BCGU_FD_D_RESET    8'h01

`endif

// ### tb/bcgu_core_assertions.sv
// Port checks of the base clock generation core, bound to it.
// Assumes outputs simply freeze while the clock enable is low.
`timescale 1ns/10ps
module bcgu_core_assertions #(
	parameter IS_SECOND = 0
) (
	input wire        mclk,
	input wire        rst_n,
	input wire        psel,
	input wire        penable,
	input wire [31:0] prdata,
	input wire        pready,
	input wire [11:0] base_clk,
	input wire        pll_fb_clk,
	input wire        pll_powerdown,
	input wire        clk_out_pin,
	input wire [11:0] clk_on_evt,
	input wire [11:0] clk_off_evt
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	chk_rsvd_clk_low: assert property (base_clk[10] == 1'h0)
		else $error("reserved base clock active");
	chk_ring_pair: assert property (base_clk[0] == base_clk[2])
		else $error("safe and control clocks differ");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_ready_access: assert property (pready |-> $past(psel && penable))
		else $error("pready without access phase");
	chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside pready");
	// Three cycles let the divider reset reach the registered output
	chk_pd_fb_low: assert property (pll_powerdown [*3] |-> !pll_fb_clk)
		else $error("feedback clock runs in power-down");
	chk_pin_unused: assert property (IS_SECOND == 0 |-> !clk_out_pin)
		else $error("output pin driven in first instance");
	chk_evt_excl: assert property ((clk_on_evt & clk_off_evt) == 12'h0)
		else $error("on and off event together");
endmodule

bind bcgu_core bcgu_core_assertions #(.IS_SECOND(IS_SECOND)) bcgu_core_assertions_i (
	.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .prdata(prdata),
	.pready(pready), .base_clk(base_clk), .pll_fb_clk(pll_fb_clk),
	.pll_powerdown(pll_powerdown), .clk_out_pin(clk_out_pin),
	.clk_on_evt(clk_on_evt), .clk_off_evt(clk_off_evt)
);

// ### tb/bcgu_xtal_model.sv
// Crystal or external clock source model driving the crystal pin.
// Assumes the bench starts and stops it; the stopped level is selectable.
`timescale 1ns/10ps
module bcgu_xtal_model #(
	parameter HALF_NS = 40
) (
	input  wire run,
	input  wire stop_high,
	output reg  xtal_in
);
	initial xtal_in = 1'h0;
	// A stopped source sits at a fixed level, so a stuck-high case can be made
	always begin
		#HALF_NS;
		if (run)
			xtal_in = ~xtal_in;
		else
			xtal_in = stop_high;
	end
endmodule

// ### tb/tb_base_clock_generation_unit.sv
// Self-checking bench for the base clock generation core, driven over APB.
// Assumes source pins slower than mclk/2 and one-cycle pready pulses.
`timescale 1ns/10ps
`include "bcgu_defines.vh"
module tb_base_clock_generation_unit;
	reg         mclk = 1'h0;
	reg         rst_n = 1'h0;
	reg         psel = 1'h0;
	reg         penable = 1'h0;
	reg         pwrite = 1'h0;
	reg  [7:0]  paddr = 8'h00;
	reg  [31:0] pwdata = 32'h0;
	reg         ring_oscillator = 1'h0;
	reg         pll_core_in = 1'h0;
	reg         pll_lock_in = 1'h0;
	reg         ring_run = 1'h0;
	reg         xtal_run = 1'h0;
	reg         xtal_high = 1'h0;
	reg         ce = 1'h1;
	reg         usb_a = 1'h0;
	reg         usb_b = 1'h0;
	reg         evt_clr = 1'h0;
	reg  [11:0] seen_on = 12'h0;
	reg  [11:0] seen_off = 12'h0;
	reg  [31:0] rd;
	reg         err;
	wire [31:0] prdata;
	wire        pready, pslverr, xtal_in, pll_ref_clk, pll_fb_clk, pll_powerdown;
	wire [11:0] base_clk, clk_on_evt, clk_off_evt;
	integer     miscompares = 0;
	integer     n_compared = 0;
	integer     cycles = 0;
	integer     cnt_b, cnt_r, cnt_f;

	always #5 mclk = ~mclk;
	// Ring held off through t_reset, so its first status read sees the empty state
	always #80 ring_oscillator = ring_run & ~ring_oscillator;
	always #50 pll_core_in = ~pll_core_in;
	always #30 usb_a = ~usb_a;
	always #70 usb_b = ~usb_b;

	bcgu_xtal_model #(.HALF_NS(40)) bcgu_xtal_model_i (
		.run(xtal_run), .stop_high(xtal_high), .xtal_in(xtal_in)
	);
	bcgu_core #(.IS_SECOND(0), .FD_W(8), .M_W(8)) bcgu_core_i (
		.mclk(mclk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ring_oscillator(ring_oscillator),
		.xtal_in(xtal_in), .pll_core_in(pll_core_in), .pll_lock_in(pll_lock_in),
		.usb_gen_input_a(usb_a), .usb_gen_input_b(usb_b), .base_clk(base_clk),
		.pll_ref_clk(pll_ref_clk), .pll_fb_clk(pll_fb_clk),
		.pll_powerdown(pll_powerdown), .clk_out_pin(), .clk_on_evt(clk_on_evt),
		.clk_off_evt(clk_off_evt)
	);

	always @(posedge mclk) begin
		cycles <= cycles + 1;
		seen_on <= (evt_clr ? 12'h0 : seen_on) | clk_on_evt;
		seen_off <= (evt_clr ? 12'h0 : seen_off) | clk_off_evt;
		if (cycles == 20000) begin
			miscompares = miscompares + 1;
			conclude;
		end
	end

	// Entered right after a rising edge; leaves one idle edge before returning
	task apb(input w, input [7:0] a, input [31:0] d);
		begin
			psel <= 1'h1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge mclk);
			penable <= 1'h1;
			@(posedge mclk);
			while (pready !== 1'h1)
				@(posedge mclk);
			rd = prdata;
			err = pslverr;
			psel <= 1'h0;
			penable <= 1'h0;
			@(posedge mclk);
		end
	endtask

	task chk(input [8*16:1] w, input [31:0] e, input [31:0] g);
		begin
			n_compared = n_compared + 1;
			if (g !== e) begin
				miscompares = miscompares + 1;
				$display("unexpected %0s: expected %h seen %h", w, e, g);
			end
		end
	endtask

	task near(input [8*16:1] w, input integer e, input integer g);
		begin
			n_compared = n_compared + 1;
			if ((g >= e - 1 && g <= e + 1) !== 1'h1) begin
				miscompares = miscompares + 1;
				$display("unexpected %0s: expected %0d seen %0d", w, e, g);
			end
		end
	endtask

	task rchk(input [8*16:1] w, input [7:0] a, input [31:0] e);
		begin
			apb(1'h0, a, 32'h0);
			chk(w, e, rd);
		end
	endtask

	task clear_evt;
		begin
			evt_clr <= 1'h1;
			@(posedge mclk);
			evt_clr <= 1'h0;
		end
	endtask

	task count(input integer n);
		reg pb, pr, pf;
		begin
			cnt_b = 0;
			cnt_r = 0;
			cnt_f = 0;
			pb = base_clk[1];
			pr = pll_ref_clk;
			pf = pll_fb_clk;
			repeat (n) begin
				@(posedge mclk);
				cnt_b = cnt_b + (base_clk[1] & ~pb);
				cnt_r = cnt_r + (pll_ref_clk & ~pr);
				cnt_f = cnt_f + (pll_fb_clk ^ pf);
				pb = base_clk[1];
				pr = pll_ref_clk;
				pf = pll_fb_clk;
			end
		end
	endtask

	task t_reset;
		integer g;
		begin
			rchk("status", `BCGU_OFS_STATUS, 32'h0);
			for (g = 0; g < 12; g = g + 1)
				rchk("base sel", {g[5:0], 2'h0}, 32'h0);
			for (g = 0; g < 7; g = g + 1)
				rchk("divider", `BCGU_OFS_FDIV0 + {g[5:0], 2'h0}, 32'h0000_0101);
			rchk("pll ctl", `BCGU_OFS_PLL, `BCGU_PLL_RESET);
			rchk("unmapped", 8'hFC, 32'h0);
			chk("unmapped err", 32'h1, {31'h0, err});
			chk("pd pin", 32'h1, {31'h0, pll_powerdown});
			$display("t_reset done");
		end
	endtask

	task t_detect;
		begin
			apb(1'h1, `BCGU_OFS_EVTEN, 32'h0FFF_0FFF);
			clear_evt;
			ring_run = 1'h1;
			xtal_run = 1'h1;
			repeat (60) @(posedge mclk);
			apb(1'h0, `BCGU_OFS_STATUS, 32'h0);
			chk("present", 32'h3, rd & 32'h3);
			chk("on events", 32'h3, {30'h0, seen_on[1:0]});
			$display("t_detect done");
		end
	endtask

	task t_select;
		begin
			apb(1'h1, `BCGU_OFS_BASE0, 32'h0100_0000);
			rchk("safe sel", `BCGU_OFS_BASE0, 32'h0);
			apb(1'h1, `BCGU_OFS_FDIV0, 32'h0500_0703);
			rchk("div fields", `BCGU_OFS_FDIV0, 32'h0000_0703);
			apb(1'h1, `BCGU_OFS_PLL, 32'h0200_0501);
			rchk("pll sel", `BCGU_OFS_PLL, 32'h0000_0501);
			apb(1'h1, 8'h28, 32'h0100_0000);
			rchk("reserved", 8'h28, 32'h0);
			apb(1'h1, 8'h04, 32'h0100_0000);
			rchk("sys sel", 8'h04, 32'h0100_0000);
			repeat (40) @(posedge mclk);
			count(400);
			near("sys clock", 50, cnt_b);
			near("pll ref", 50, cnt_r);
			$display("t_select done");
		end
	endtask

	task t_fail;
		integer n;
		begin
			clear_evt;
			xtal_high = 1'h1;
			xtal_run = 1'h0;
			repeat (50) @(posedge mclk);
			apb(1'h0, `BCGU_OFS_STATUS, 32'h0);
			chk("absent", 32'h1, rd & 32'h3);
			chk("off event", 32'h1, {31'h0, seen_off[1]});
			rchk("kept sel", 8'h04, 32'h0100_0000);
			apb(1'h1, 8'h0C, 32'h0100_0000);
			rchk("masked sel", 8'h0C, 32'h0);
			apb(1'h1, 8'h04, 32'h0);
			n = 0;
			while (base_clk[1] !== 1'h0 && n < 45) begin
				n = n + 1;
				@(posedge mclk);
			end
			chk("forced low", 32'h0, {31'h0, base_clk[1]});
			near("force time", 34, n);
			repeat (40) @(posedge mclk);
			count(320);
			near("ring switch", 20, cnt_b);
			$display("t_fail done");
		end
	endtask

	task t_freeze;
		begin
			ce <= 1'h0;
			@(posedge mclk);
			count(100);
			chk("frozen base", 32'h0, cnt_b);
			chk("frozen ref", 32'h0, cnt_r);
			ce <= 1'h1;
			@(posedge mclk);
			$display("t_freeze done");
		end
	endtask

	task t_pll;
		integer m;
		begin
			pll_lock_in <= 1'h1;
			xtal_run = 1'h1;
			for (m = 0; m < 5; m = m + 1) begin
				apb(1'h1, `BCGU_OFS_PLL, {8'h01, 8'h00, 8'h04, 4'h0, m[1:0], m == 4, 1'h0});
				repeat (20) @(posedge mclk);
				count(1280);
				near("fb toggles", m == 4 ? 32 : 16 >> m, cnt_f);
			end
			apb(1'h0, `BCGU_OFS_STATUS, 32'h0);
			chk("lock", 32'h1, {31'h0, rd[`BCGU_ST_LOCK]});
			apb(1'h1, `BCGU_OFS_PLL, `BCGU_PLL_RESET);
			@(posedge mclk);
			chk("pd pin", 32'h1, {31'h0, pll_powerdown});
			apb(1'h0, `BCGU_OFS_STATUS, 32'h0);
			chk("lock in pd", 32'h0, {31'h0, rd[`BCGU_ST_LOCK]});
			$display("t_pll done");
		end
	endtask

	task conclude;
		begin
			$display("compared %0d, mismatched %0d", n_compared, miscompares);
			if (miscompares == 0 && n_compared > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask

	initial begin
		repeat (3) @(posedge mclk);
		rst_n <= 1'h1;
		t_reset;
		t_detect;
		t_select;
		t_fail;
		t_freeze;
		t_pll;
		conclude;
	end
endmodule
